// ### src/bcg_defs.svh
// Constants for the block code generator: register offsets, fields, counts.
// Assumes inclusion by bare name from the design files.
`ifndef BCG_DEFS_SVH
`define BCG_DEFS_SVH
`define BCG_ADDR_W 4
`define BCG_OFF_CTRL 4'h0
`define BCG_OFF_RESTART 4'h1
`define BCG_OFF_CODE1 4'h2
`define BCG_OFF_CODE2 4'h3
`define BCG_OFF_STATUS 4'h4
`define BCG_CTRL_MODE_BIT 0
`define BCG_CTRL_RST 1'b0
`define BCG_BLK_SHORT 256
`define BCG_BLK_LONG 512
`define BCG_CODE_RST 24'hFFFFFF
`endif

// ### src/bcg_pkg.sv
// Types for the block code generator.
// Assumes the defs header is compiled alongside.
package bcg_pkg;
  typedef enum logic [1:0] {
    BCG_RUN1,
    BCG_RUN2,
    BCG_DONE
  } bcg_state_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bcg_byte_s;
  typedef struct packed {
    logic [5:0] col;
    logic [17:0] line;
  } bcg_par_s;
endpackage

// ### src/bcg_block_code_gen.sv
// Block code generator: line and column parity codes over interface bytes.
// Assumes interface bytes come from logic on ref_clk, one per valid cycle.
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defs.svh"
module bcg_block_code_gen
  import bcg_pkg::*;
#(
  parameter int CNT_W = 9
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`BCG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire bcg_byte_s wave_byte,
  input wire bcg_byte_s fifo_byte,
  output logic code_block_mode_bit,
  output logic codes_done
);
  // Status field packing assumes the counter indexes one long block
  if (CNT_W != $clog2(`BCG_BLK_LONG)) begin : g_bad_cnt
    $error("CNT_W must index one long block");
  end


  localparam logic [CNT_W-1:0] LAST_SHORT = CNT_W'(`BCG_BLK_SHORT - 1);
  localparam logic [CNT_W-1:0] LAST_LONG = CNT_W'(`BCG_BLK_LONG - 1);

  bcg_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] col_acc_r;
  logic [CNT_W-1:0] line_odd_r, line_even_r;
  logic [23:0] first_code_result, second_code_result;
  logic [23:0] code1_nxt, code2_nxt;

  // Decode
  wire wr_ctrl = reg_wr && reg_addr == `BCG_OFF_CTRL;
  wire code_restart_reg = reg_wr && reg_addr == `BCG_OFF_RESTART;
  wire byte_ok = wave_byte.valid | fifo_byte.valid;
  wire [7:0] in_byte = wave_byte.valid ? wave_byte.data : fifo_byte.data;
  wire counting = byte_ok && state_r != BCG_DONE;
  wire line_par = ^in_byte;
  wire block_end = counting &&
    (code_block_mode_bit ? cnt_r == LAST_LONG : cnt_r == LAST_SHORT);

  // Running parity folded with the current byte
  wire [7:0] col_now = col_acc_r ^ in_byte;
  wire [CNT_W-1:0] lo_now = line_odd_r ^ (line_par ? cnt_r : '0);
  wire [CNT_W-1:0] le_now = line_even_r ^ (line_par ? ~cnt_r : '0);
  // Column parity pairs, odd and even for bit groups 4, 2, 1
  wire [5:0] col_bits = {
    ^col_now[7:4], ^col_now[3:0],
    ^{col_now[7:6], col_now[3:2]}, ^{col_now[5:4], col_now[1:0]},
    ^{col_now[7], col_now[5], col_now[3], col_now[1]},
    ^{col_now[6], col_now[4], col_now[2], col_now[0]}};
  // Interleave line parity odd/even per address bit; short blocks use 8 bits
  logic [17:0] line_bits;
  genvar g;
  generate
    for (g = 0; g < CNT_W; g = g + 1) begin : g_line
      assign line_bits[2*g+1] = lo_now[g] &
        (code_block_mode_bit || g < 8);
      assign line_bits[2*g] = le_now[g] & (code_block_mode_bit || g < 8);
    end
  endgenerate
  // Inverted parity so an erased all-ones block gives an all-ones code
  bcg_par_s par;
  assign par = '{col: ~col_bits, line: ~line_bits};
  wire [23:0] code_now = {par.line[15:0], par.line[17:16], par.col};

  // Result steering
  assign code1_nxt = (block_end && state_r == BCG_RUN1) ? code_now
    : first_code_result;
  assign code2_nxt = (block_end && state_r == BCG_RUN2) ? code_now
    : second_code_result;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BCG_RUN1: begin
        if (block_end) begin
          state_nxt = code_block_mode_bit ? BCG_DONE : BCG_RUN2;
        end
      end
      BCG_RUN2: begin
        if (block_end) begin
          state_nxt = BCG_DONE;
        end
      end
      BCG_DONE: state_nxt = BCG_DONE;
      default: state_nxt = BCG_DONE;
    endcase
    if (code_restart_reg) begin
      state_nxt = BCG_RUN1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= BCG_DONE;
      cnt_r <= '0;
      col_acc_r <= 8'h00;
      line_odd_r <= '0;
      line_even_r <= '0;
    end else if (code_restart_reg || block_end) begin
      state_r <= state_nxt;
      cnt_r <= '0;
      col_acc_r <= 8'h00;
      line_odd_r <= '0;
      line_even_r <= '0;
    end else if (counting) begin
      cnt_r <= cnt_r + 1'b1;
      col_acc_r <= col_now;
      line_odd_r <= lo_now;
      line_even_r <= le_now;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_code_result <= `BCG_CODE_RST;
      second_code_result <= `BCG_CODE_RST;
    end else if (code_restart_reg) begin
      first_code_result <= `BCG_CODE_RST;
      second_code_result <= `BCG_CODE_RST;
    end else begin
      first_code_result <= code1_nxt;
      second_code_result <= code2_nxt;
    end
  end

  // Mode changes mid-block take effect at once; firmware sets it first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      code_block_mode_bit <= `BCG_CTRL_RST;
    end else if (wr_ctrl) begin
      code_block_mode_bit <= reg_wdata[`BCG_CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      codes_done <= 1'b1;
    end else begin
      codes_done <= state_nxt == BCG_DONE;
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `BCG_OFF_CTRL: rd_mux = {31'h0, code_block_mode_bit};
      `BCG_OFF_CODE1: rd_mux = {8'h00, first_code_result};
      `BCG_OFF_CODE2: rd_mux = {8'h00, second_code_result};
      `BCG_OFF_STATUS: rd_mux = {22'h0, cnt_r, state_r == BCG_DONE};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Assertions
  a_restart_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    code_restart_reg |=> cnt_r == '0 && state_r == BCG_RUN1)
    else $error("restart did not clear accumulation");
  a_done_freeze1: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == BCG_DONE && !code_restart_reg
    |=> $stable(first_code_result))
    else $error("first result changed after done");
  a_done_freeze2: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == BCG_DONE && !code_restart_reg
    |=> $stable(second_code_result))
    else $error("second result changed after done");
  a_long_unused2: assert property (@(posedge ref_clk) disable iff (!nrst)
    code_block_mode_bit && !code_restart_reg
    |=> $stable(second_code_result))
    else $error("second result written in long mode");
  a_short_first: assert property (@(posedge ref_clk) disable iff (!nrst)
    !code_block_mode_bit && counting && state_r == BCG_RUN1
    && cnt_r == LAST_SHORT |=> state_r == BCG_RUN2)
    else $error("short block did not end at 256 bytes");
  a_long_once: assert property (@(posedge ref_clk) disable iff (!nrst)
    code_block_mode_bit && block_end && !code_restart_reg
    |=> state_r == BCG_DONE)
    else $error("long block did not finish");
  a_result1_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    block_end && state_r == BCG_RUN1 && !code_restart_reg
    |=> first_code_result == $past(code_now))
    else $error("first result not loaded");
  a_count_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == BCG_DONE && !code_restart_reg |=> $stable(cnt_r))
    else $error("counter moved after final block");
  a_mode_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_ctrl |=> code_block_mode_bit == $past(reg_wdata[0]))
    else $error("mode bit not written");

  // Result, counter, state, lane and read-back checks
  a_restart_results: assert property (
    @(posedge ref_clk) disable iff (!nrst) code_restart_reg
    |=> first_code_result == `BCG_CODE_RST
    && second_code_result == `BCG_CODE_RST)
    else $error("restart did not reset results");
  a_result2_load: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    block_end && state_r == BCG_RUN2 && !code_restart_reg
    |=> second_code_result == $past(code_now))
    else $error("second result not loaded");
  a_short_second: assert property (
    @(posedge ref_clk) disable iff (!nrst) !code_block_mode_bit && counting
    && state_r == BCG_RUN2 && cnt_r == LAST_SHORT && !code_restart_reg
    |=> state_r == BCG_DONE)
    else $error("second short block did not finish");
  a_long_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst) code_block_mode_bit && counting
    && state_r == BCG_RUN1 && cnt_r != LAST_LONG && !code_restart_reg
    |=> state_r == BCG_RUN1)
    else $error("long block ended early");
  a_count_step: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    counting && !block_end && !code_restart_reg
    |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter did not advance on a byte");
  a_idle_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !byte_ok && !code_restart_reg
    |=> $stable(cnt_r))
    else $error("counter moved without a byte");
  a_done_flag: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    1'b1
    |-> codes_done == (state_r == BCG_DONE))
    else $error("done flag disagrees with state");
  a_rdata_idle: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !reg_rd
    |=> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_rdata_code1: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `BCG_OFF_CODE1
    |=> reg_rdata == {8'h00, $past(first_code_result)})
    else $error("first result read back wrong");
  a_rdata_code2: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `BCG_OFF_CODE2
    |=> reg_rdata == {8'h00, $past(second_code_result)})
    else $error("second result read back wrong");
  a_rdata_mode: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `BCG_OFF_CTRL
    |=> reg_rdata == {31'h0, $past(code_block_mode_bit)})
    else $error("mode bit read back wrong");
  a_short_top: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !code_block_mode_bit
    |-> code_now[7:6] == 2'b11)
    else $error("short code top line bits not set");
  a_wave_first: assert property (
    @(posedge ref_clk) disable iff (!nrst) wave_byte.valid
    && fifo_byte.valid && counting && !block_end && !code_restart_reg
    |=> col_acc_r == $past(col_acc_r ^ wave_byte.data))
    else $error("waveform lane did not win");

  // Main scenarios
  c_short_pair: cover property (@(posedge ref_clk) disable iff (!nrst)
    !code_block_mode_bit && block_end && state_r == BCG_RUN2);
  c_long_done: cover property (@(posedge ref_clk) disable iff (!nrst)
    code_block_mode_bit && block_end);
  c_restart_mid: cover property (@(posedge ref_clk) disable iff (!nrst)
    code_restart_reg && state_r != BCG_DONE);
  c_long_restart: cover property (@(posedge ref_clk) disable iff (!nrst)
    code_block_mode_bit && code_restart_reg);
  c_both_lanes: cover property (@(posedge ref_clk) disable iff (!nrst)
    wave_byte.valid && fifo_byte.valid);
endmodule
`default_nettype wire

// ### test/bcg_byte_src.sv
// Far-side model: waveform and slave FIFO byte lanes.
// Assumes ref_clk from the bench; lanes are byte wide only.
`timescale 1ns/1ns
`default_nettype none
module bcg_byte_src
  import bcg_pkg::*;
(
  input wire logic ref_clk,
  output var bcg_byte_s wave_byte,
  output var bcg_byte_s fifo_byte
);
  initial begin
    wave_byte = '0;
    fifo_byte = '0;
  end
  // Byte 0 carries b0, the rest zero; 8-bit transfers only
  task automatic send(input logic lane, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (lane) fifo_byte <= '{1'b1, (i == 0) ? b0 : 8'h00};
      else wave_byte <= '{1'b1, (i == 0) ? b0 : 8'h00};
    end
    // Released lanes show inverted data so stale bytes never look valid
    @(posedge ref_clk);
    wave_byte <= '{1'b0, ~wave_byte.data};
    fifo_byte <= '{1'b0, ~fifo_byte.data};
    // Let the design's outputs settle before the caller looks at them
    #1;
  endtask
endmodule
`default_nettype wire

// ### test/block_ecc_generator_test.sv
// Bench for the block code generator with a byte source model.
// Assumes the package, defs header and design are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defs.svh"
module block_ecc_generator_test;
  import bcg_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  bcg_byte_s wave_byte;
  bcg_byte_s fifo_byte;
  logic code_block_mode_bit;
  logic codes_done;
  logic [31:0] d;
  int n_errors = 0;
  int samples_checked = 0;
  always #50 ref_clk = ~ref_clk;
  bcg_block_code_gen #(.CNT_W(9)) bcg_block_code_gen_i (.ref_clk(ref_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wave_byte(wave_byte), .fifo_byte(fifo_byte),
    .code_block_mode_bit(code_block_mode_bit), .codes_done(codes_done));
  bcg_byte_src bcg_byte_src_i (.ref_clk(ref_clk), .wave_byte(wave_byte),
    .fifo_byte(fifo_byte));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Single set bit 0 at block byte 0 gives AAAAEA short, AAAAAA long
  task automatic t_short();
    wr(`BCG_OFF_CTRL, 8'h00);
    wr(`BCG_OFF_RESTART, 8'h5A);
    bcg_byte_src_i.send(1'b0, 256, 8'h01);
    chk({31'h0, codes_done}, 32'h0);
    bcg_byte_src_i.send(1'b1, 256, 8'h80);
    chk({31'h0, codes_done}, 32'h1);
    bcg_byte_src_i.send(1'b0, 20, 8'hFF);
    rd(`BCG_OFF_CODE1, d);
    chk(d, 32'h00AAAAEA);
    rd(`BCG_OFF_CODE2, d);
    chk(d, 32'h00AAAAD5);
    rd(4'hF, d);
    chk(d, 32'h0);
  endtask
  // Restart mid-block must discard the partial accumulation
  task automatic t_long();
    wr(`BCG_OFF_CTRL, 8'h01);
    chk({31'h0, code_block_mode_bit}, 32'h1);
    wr(`BCG_OFF_RESTART, 8'h00);
    bcg_byte_src_i.send(1'b0, 100, 8'h01);
    wr(`BCG_OFF_RESTART, 8'hFF);
    rd(`BCG_OFF_CODE1, d);
    chk(d, 32'h00FFFFFF);
    bcg_byte_src_i.send(1'b1, 512, 8'h01);
    bcg_byte_src_i.send(1'b1, 30, 8'h01);
    rd(`BCG_OFF_CODE1, d);
    chk(d, 32'h00AAAAAA);
    rd(`BCG_OFF_CODE2, d);
    chk(d, 32'h00FFFFFF);
    rd(`BCG_OFF_STATUS, d);
    chk({31'h0, d[0]}, 32'h1);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_short();
    t_long();
    final_report();
  end
  // Hang guard well above the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
